// File: shared/sac_params.svh
// constants for the status, auxiliary control and clock control tile
// assumes a 32-bit AXI4-Lite bus with byte addresses on 8 bits
//
// Function
// - sync mode turns status register into 4-bit two-stage synchronizer on status clock
// - sync mode takes four status inputs to four sync pins, pins forced output
// - sync mode disables normal status reads and forces sticky capture off
// - sync mode leaves control alone; routed reload and gate must stay disabled
// - eight-bit auxiliary control: flushes, thresholds, interrupt gate, counter run
// - writing 1 to flush clears that FIFO; software writes 0 to resume
// - while flush is held the FIFO is a one-byte buffer without status
// - threshold 0: status means not full for input, not empty for output
// - threshold 1: status means two writable for input, two readable for output
// - interrupt gate bit gates the generated status interrupt
// - counter run starts and stops the counter only in counter output mode
// - control and mask double as count and period; no interrupt in counter mode
// - in sync mode the mask serves only as counter period
// - one reset block and four clock circuits fed by four routed inputs
// - one routed input chosen as external clock, optionally resynchronised
// - six clock sources per component; codes above them are unsupported
// - routed reset to logic blocks and counter, firmware reset per component
// - optional clock inversion; no simultaneous bus and internal count writes
// - clock enable picked from any routed input, optionally inverted
// - two-bit enable mode: off, on, positive edge, level; off after reset
// - positive edge: one clock per enable rise; level: clocks while enable high
`ifndef SAC_PARAMS_SVH
`define SAC_PARAMS_SVH

// register byte offsets
`define SAC_OFF_AUX 8'h00
`define SAC_OFF_CFG 8'h04
`define SAC_OFF_CTL 8'h08
`define SAC_OFF_MASK 8'h0C
`define SAC_OFF_STATUS 8'h10
`define SAC_OFF_FIFO 8'h14
`define SAC_OFF_FWRST 8'h18
`define SAC_CLK_REGION 4'h2

// auxiliary control bits
`define SAC_AUX_FLUSH 0
`define SAC_AUX_THR 2
`define SAC_AUX_IRQ 4
`define SAC_AUX_RUN 5

// codes and reset values
`define SAC_OUTSEL_COUNTER 2'h1
`define SAC_SRC_APP 3'h4
`define SAC_SRC_EXT 3'h5
`define SAC_FIFO_FULL 3'h4
`define SAC_FIFO_HALF 3'h2
`define SAC_FIFO_ONE 3'h1
`define SAC_ZERO8 8'h00
`define SAC_ZERO7 7'h00
`define SAC_ZERO32 32'h0000_0000
`define SAC_ALL4 4'hF
`define SAC_RESP_OKAY 2'h0
`define SAC_RESP_SLVERR 2'h2
`define SAC_SC_COMP 3

`endif

// File: shared/sac_pkg.sv
// types for the status, auxiliary control and clock control tile
// assumes sac_params.svh for offsets and codes
package sac_pkg;

  typedef enum logic [1:0] {
    CLK_OFF = 2'b00,
    CLK_ON = 2'b01,
    CLK_POSEDGE = 2'b10,
    CLK_LEVEL = 2'b11
  } clk_mode_t;

  // one clock control circuit, low nine bits of its word
  typedef struct packed {
    clk_mode_t mode;
    logic enInv;
    logic [1:0] enSel;
    logic inv;
    logic [2:0] src;
  } clk_cfg_t;

  // status and control configuration word
  typedef struct packed {
    logic [7:0] spare;
    logic [1:0] gateSel;
    logic [1:0] reloadSel;
    logic [1:0] resetSel;
    logic resetEn;
    logic extSync;
    logic [1:0] extSel;
    logic [7:0] stickyMask;
    logic intGenEn;
    logic gateEn;
    logic reloadEn;
    logic [1:0] outSel;
    logic syncMode;
  } sc_cfg_t;

  // fill state of one datapath FIFO
  typedef struct packed {
    logic outputMode;
    logic [2:0] count;
  } fifo_state_t;

endpackage

// File: src/status_aux_clock_control.sv
// status/control sub-block with auxiliary control and reset/clock control
// assumes pins are asynchronous, fabric status and FIFO state share the bus clock
`timescale 1ns/1ps
`include "sac_params.svh"

module status_aux_clock_control
  import sac_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // axi4-lite slave
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // clock pins
  input wire logic [3:0] peripheralClocks,
  input wire logic appFastClock,
  input wire logic [3:0] routedControlInputs,
  // fabric side
  input wire logic [7:0] statusInputs,
  input wire fifo_state_t [1:0] fifoState,
  output logic [3:0] syncOutputPins,
  output logic [3:0] syncOutputEnable,
  output logic [7:0] controlOut,
  output logic statusIrq,
  output logic [1:0] fifoBusStatus,
  output logic [1:0] fifoFlush,
  output logic [3:0] componentClockEnable,
  output logic routedReset,
  output logic [3:0] firmwareReset
);

  // registers
  logic [7:0] auxControl;
  sc_cfg_t cfg;
  logic [7:0] control;
  logic [7:0] mask;
  logic [7:0] sticky;
  logic [3:0] syncStage1;
  logic [3:0] syncStage2;
  clk_cfg_t clkCfg [4];
  logic [8:0] pinS1;
  logic [8:0] pinS2;
  logic [8:0] pinS3;
  logic [8:0] pinF;
  logic extReg;
  logic awGot;
  logic wGot;
  logic [7:0] wAddr;
  logic [31:0] wData;
  logic [3:0] wStrb;

  // byte-lane merge of a bus write
  function automatic logic [31:0] mergeWord(input logic [31:0] old, input logic [31:0] data,
                                            input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[b*8 +: 8] = data[b*8 +: 8];
      end
    end
    return res;
  endfunction

  // axi write channel and read handshake
  wire awTake = awvalid & awready;
  wire wTake = wvalid & wready;
  wire haveAw = awGot | awTake;
  wire haveW = wGot | wTake;
  wire doWrite = haveAw & haveW;
  wire [7:0] curWAddr = awTake ? awaddr : wAddr;
  wire [31:0] curWData = wTake ? wdata : wData;
  wire [3:0] curWStrb = wTake ? wstrb : wStrb;
  wire next_awGot = haveAw & ~doWrite;
  wire next_wGot = haveW & ~doWrite;
  wire next_bvalid = doWrite | (bvalid & ~bready);
  wire arTake = arvalid & arready;
  wire next_rvalid = arTake | (rvalid & ~rready);

  // write decode
  wire wrAux = doWrite & (curWAddr == `SAC_OFF_AUX);
  wire wrCfg = doWrite & (curWAddr == `SAC_OFF_CFG);
  wire wrCtl = doWrite & (curWAddr == `SAC_OFF_CTL);
  wire wrMask = doWrite & (curWAddr == `SAC_OFF_MASK);
  wire wrFw = doWrite & (curWAddr == `SAC_OFF_FWRST);
  wire wrClkRegion = doWrite & (curWAddr[7:4] == `SAC_CLK_REGION);
  wire wrMapped = wrAux | wrCfg | wrCtl | wrMask | wrFw | wrClkRegion |
                  (curWAddr == `SAC_OFF_STATUS) | (curWAddr == `SAC_OFF_FIFO);
  wire [31:0] auxMerged = mergeWord({24'h00_0000, auxControl}, curWData, curWStrb);
  wire [31:0] cfgMerged = mergeWord(cfg, curWData, curWStrb);
  wire [31:0] ctlMerged = mergeWord({24'h00_0000, control}, curWData, curWStrb);
  wire [31:0] maskMerged = mergeWord({24'h00_0000, mask}, curWData, curWStrb);
  wire [31:0] fwMerged = mergeWord({28'h000_0000, firmwareReset}, curWData, curWStrb);

  // filtered pins: rc[3:0], peripheral clocks, app fast clock
  wire [3:0] rcF = pinF[3:0];
  wire [3:0] gclkF = pinF[7:4];
  wire appF = pinF[8];

  // mode decode
  wire counterMode = cfg.outSel == `SAC_OUTSEL_COUNTER;
  wire scTick = componentClockEnable[`SAC_SC_COMP];
  wire counterRun = auxControl[`SAC_AUX_RUN];
  wire gateActive = cfg.gateEn & ~cfg.syncMode;
  wire gateOk = ~gateActive | rcF[cfg.gateSel];
  wire reloadActive = cfg.reloadEn & ~cfg.syncMode & rcF[cfg.reloadSel] & gateOk;
  wire counting = counterMode & counterRun & gateOk;
  wire [6:0] count = control[6:0];
  wire terminal = count == `SAC_ZERO7;
  wire countWriteOk = ~(counterMode & counterRun);

  // status view and interrupt
  wire [7:0] statusView = (sticky & cfg.stickyMask) | (statusInputs & ~cfg.stickyMask);
  wire intRaw = |(mask[6:0] & statusView[6:0]);
  wire next_irq = intRaw & cfg.intGenEn & auxControl[`SAC_AUX_IRQ] & ~counterMode & ~cfg.syncMode;
  // sticky off in sync, set wins
  wire clearRead = arTake & (araddr == `SAC_OFF_STATUS);
  wire [7:0] stickySet = (scTick ? statusInputs & cfg.stickyMask : `SAC_ZERO8);
  wire [7:0] next_sticky = cfg.syncMode ? `SAC_ZERO8 : stickySet | (sticky & ~{8{clearRead}});
  wire [7:0] statusRead = cfg.syncMode ? {4'h0, syncStage2} :
                          {cfg.intGenEn ? statusIrq : statusView[7], statusView[6:0]};

  logic [1:0] next_fifoStatus;
  for (genvar f = 0; f < 2; f++) begin : g_fifo
    wire thr = auxControl[`SAC_AUX_THR + f];
    wire fl = auxControl[`SAC_AUX_FLUSH + f];
    wire [2:0] cnt = fifoState[f].count;
    wire inOk = thr ? (cnt <= `SAC_FIFO_HALF) : (cnt < `SAC_FIFO_FULL);
    wire outOk = thr ? (cnt >= `SAC_FIFO_HALF) : (cnt >= `SAC_FIFO_ONE);
    assign next_fifoStatus[f] = ~fl & (fifoState[f].outputMode ? outOk : inOk);
  end

  wire extRaw = rcF[cfg.extSel];
  wire extClk = cfg.extSync ? extReg : extRaw;
  wire [7:0] srcVec = {2'b00, extClk, appF, gclkF};

  logic [3:0] next_clkEn;
  logic [3:0] prevSrc;
  logic [3:0] prevEn;
  logic [3:0] pend;
  logic [3:0] curSrc;
  logic [3:0] curEn;
  logic [3:0] next_pend;
  for (genvar c = 0; c < 4; c++) begin : g_clk
    assign curSrc[c] = srcVec[clkCfg[c].src];
    wire edgeHit = clkCfg[c].inv ? (prevSrc[c] & ~curSrc[c]) : (~prevSrc[c] & curSrc[c]);
    assign curEn[c] = rcF[clkCfg[c].enSel] ^ clkCfg[c].enInv;
    wire armed = pend[c] | (curEn[c] & ~prevEn[c]);
    wire isPos = clkCfg[c].mode == CLK_POSEDGE;
    assign next_clkEn[c] = edgeHit & ((clkCfg[c].mode == CLK_ON) |
                                      ((clkCfg[c].mode == CLK_LEVEL) & curEn[c]) | (isPos & armed));
    assign next_pend[c] = isPos & armed & ~edgeHit;
  end

  // read mux
  wire [31:0] clkWord = {23'h00_0000, clkCfg[araddr[3:2]]};
  wire rdClk = araddr[7:4] == `SAC_CLK_REGION;
  wire rdHit = rdClk | (araddr == `SAC_OFF_AUX) | (araddr == `SAC_OFF_CFG) | (araddr == `SAC_OFF_CTL) |
               (araddr == `SAC_OFF_MASK) | (araddr == `SAC_OFF_STATUS) | (araddr == `SAC_OFF_FIFO) |
               (araddr == `SAC_OFF_FWRST);
  wire [31:0] readMux =
    rdClk ? clkWord :
    (araddr == `SAC_OFF_AUX) ? {24'h00_0000, auxControl} :
    (araddr == `SAC_OFF_CFG) ? cfg :
    (araddr == `SAC_OFF_CTL) ? {24'h00_0000, control} :
    (araddr == `SAC_OFF_MASK) ? {24'h00_0000, mask} :
    (araddr == `SAC_OFF_STATUS) ? {24'h00_0000, statusRead} :
    (araddr == `SAC_OFF_FIFO) ? {30'h0000_0000, fifoBusStatus} :
    (araddr == `SAC_OFF_FWRST) ? {28'h000_0000, firmwareReset} : `SAC_ZERO32;

  // bus handshake registers
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      awGot <= 1'b0;
      wGot <= 1'b0;
      awready <= 1'b0;
      wready <= 1'b0;
      bvalid <= 1'b0;
      bresp <= `SAC_RESP_OKAY;
      arready <= 1'b0;
      rvalid <= 1'b0;
      rresp <= `SAC_RESP_OKAY;
      rdata <= `SAC_ZERO32;
      wAddr <= `SAC_ZERO8;
      wData <= `SAC_ZERO32;
      wStrb <= 4'h0;
    end else begin
      awGot <= next_awGot;
      wGot <= next_wGot;
      awready <= ~next_awGot & ~next_bvalid;
      wready <= ~next_wGot & ~next_bvalid;
      bvalid <= next_bvalid;
      arready <= ~next_rvalid;
      rvalid <= next_rvalid;
      if (awTake) begin
        wAddr <= awaddr;
      end
      if (wTake) begin
        wData <= wdata;
        wStrb <= wstrb;
      end
      if (doWrite) begin
        bresp <= wrMapped ? `SAC_RESP_OKAY : `SAC_RESP_SLVERR;
      end
      if (arTake) begin
        rdata <= readMux;
        rresp <= rdHit ? `SAC_RESP_OKAY : `SAC_RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      auxControl <= `SAC_ZERO8;
      cfg <= `SAC_ZERO32;
      mask <= `SAC_ZERO8;
      firmwareReset <= 4'h0;
    end else begin
      if (wrAux) begin
        auxControl <= {2'b00, auxMerged[5:0]};
      end
      if (wrCfg) begin
        cfg <= cfgMerged;
      end
      if (wrMask) begin
        mask <= maskMerged[7:0];
      end
      if (wrFw) begin
        firmwareReset <= fwMerged[3:0];
      end
    end
  end

  for (genvar c = 0; c < 4; c++) begin : g_clkreg
    wire wrThis = wrClkRegion & (curWAddr[3:2] == 2'(c));
    wire [31:0] merged = mergeWord({23'h00_0000, clkCfg[c]}, curWData, curWStrb);
    always_ff @(posedge clock) begin
      if (!rst_n) begin
        clkCfg[c] <= '0;
      end else if (wrThis) begin
        clkCfg[c] <= merged[8:0];
      end
    end
  end

  // control doubles as count, mask as period
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      control <= `SAC_ZERO8;
    end else if (counterMode & routedReset) begin
      control <= `SAC_ZERO8;
    end else if (wrCtl & countWriteOk) begin
      control <= ctlMerged[7:0];
    end else if (scTick & counting) begin
      control <= {1'b0, (reloadActive | terminal) ? mask[6:0] : count - 7'h01};
    end
  end

  // pin synchronisers and clock circuits
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      pinS1 <= '0;
      pinS2 <= '0;
      pinS3 <= '0;
      pinF <= '0;
      extReg <= 1'b0;
      prevSrc <= 4'h0;
      prevEn <= 4'h0;
      pend <= 4'h0;
      componentClockEnable <= 4'h0;
    end else begin
      pinS1 <= {appFastClock, peripheralClocks, routedControlInputs};
      pinS2 <= pinS1;
      pinS3 <= pinS2;
      pinF <= (pinS2 == pinS3) ? pinS3 : pinF;
      extReg <= extRaw;
      prevSrc <= curSrc;
      prevEn <= curEn;
      pend <= next_pend;
      componentClockEnable <= next_clkEn;
    end
  end

  // status, sync and fabric outputs
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      sticky <= `SAC_ZERO8;
      syncStage1 <= 4'h0;
      syncStage2 <= 4'h0;
      syncOutputPins <= 4'h0;
      syncOutputEnable <= 4'h0;
      controlOut <= `SAC_ZERO8;
      statusIrq <= 1'b0;
      fifoBusStatus <= 2'b00;
      fifoFlush <= 2'b00;
      routedReset <= 1'b0;
    end else begin
      sticky <= next_sticky;
      if (cfg.syncMode & scTick) begin
        syncStage1 <= statusInputs[3:0];
        syncStage2 <= syncStage1;
      end
      syncOutputPins <= cfg.syncMode ? syncStage2 : 4'h0;
      syncOutputEnable <= cfg.syncMode ? `SAC_ALL4 : 4'h0;
      controlOut <= counterMode ? {terminal, count} : control;
      statusIrq <= next_irq;
      fifoBusStatus <= next_fifoStatus;
      fifoFlush <= auxControl[`SAC_AUX_FLUSH +: 2];
      // routed reset from a routed input
      routedReset <= cfg.resetEn & rcF[cfg.resetSel];
    end
  end

  // checks
  a_sync_pin_drive: assert property (@(posedge clock) disable iff (!rst_n)
    cfg.syncMode ##1 cfg.syncMode |-> syncOutputEnable == `SAC_ALL4 && syncOutputPins == $past(syncStage2))
    else $error("sync pins not driven from synchronizer");
  a_sticky_forced_off: assert property (@(posedge clock) disable iff (!rst_n)
    $past(cfg.syncMode) |-> sticky == `SAC_ZERO8)
    else $error("sticky capture active in sync mode");
  a_irq_gate_off: assert property (@(posedge clock) disable iff (!rst_n)
    !auxControl[`SAC_AUX_IRQ] |=> !statusIrq)
    else $error("interrupt escaped closed gate");
  a_irq_counter_mode: assert property (@(posedge clock) disable iff (!rst_n)
    (counterMode || cfg.syncMode) |=> !statusIrq)
    else $error("interrupt in counter or sync mode");
  a_flush_no_status: assert property (@(posedge clock) disable iff (!rst_n)
    auxControl[`SAC_AUX_FLUSH] |=> !fifoBusStatus[0])
    else $error("flushed fifo shows status");
  a_fifo_low_thr: assert property (@(posedge clock) disable iff (!rst_n)
    !auxControl[`SAC_AUX_FLUSH] && !auxControl[`SAC_AUX_THR] && !fifoState[0].outputMode &&
    fifoState[0].count == `SAC_FIFO_FULL |=> !fifoBusStatus[0])
    else $error("full input fifo reports room");
  a_fifo_half_thr: assert property (@(posedge clock) disable iff (!rst_n)
    !auxControl[`SAC_AUX_FLUSH] && auxControl[`SAC_AUX_THR] && fifoState[0].outputMode &&
    fifoState[0].count == `SAC_FIFO_ONE |=> !fifoBusStatus[0])
    else $error("one byte reported as half full");
  a_count_stopped: assert property (@(posedge clock) disable iff (!rst_n)
    counterMode && !counterRun && !wrCtl && !routedReset |=> $stable(control[6:0]))
    else $error("counter moved while stopped");
  a_count_reload: assert property (@(posedge clock) disable iff (!rst_n)
    scTick && counting && terminal && !routedReset && !wrCtl |=> control[6:0] == $past(mask[6:0]))
    else $error("no reload at terminal count");
  a_clk_mode_off: assert property (@(posedge clock) disable iff (!rst_n)
    clkCfg[`SAC_SC_COMP].mode == CLK_OFF |=> !componentClockEnable[`SAC_SC_COMP])
    else $error("clock ran in off mode");
  a_write_answer: assert property (@(posedge clock) disable iff (!rst_n)
    doWrite |=> bvalid ##0 !awready [*1])
    else $error("write not answered next cycle");
  c_sync_tick: cover property (@(posedge clock) disable iff (!rst_n) cfg.syncMode && scTick);
  c_count_reload: cover property (@(posedge clock) disable iff (!rst_n) scTick && counting && terminal);
  c_posedge_tick: cover property (@(posedge clock) disable iff (!rst_n)
    clkCfg[0].mode == CLK_POSEDGE && componentClockEnable[0]);
  c_status_clear: cover property (@(posedge clock) disable iff (!rst_n) clearRead && |sticky);

endmodule // status_aux_clock_control

// File: tb/fabric_model.sv
// fabric-side clock sources for the status/aux/clock tile
// assumes nothing; free-running divider outputs unrelated to the bus clock
`timescale 1ns/1ps

module fabric_model (
  // clock sources
  output logic [3:0] peripheralClocks,
  output logic appFastClock
);
  initial begin
    peripheralClocks = 4'h0;
    forever #30 peripheralClocks = ~peripheralClocks;
  end
  initial begin
    appFastClock = 1'b0;
    forever #24 appFastClock = ~appFastClock;
  end
endmodule // fabric_model

// File: tb/status_aux_clock_control_tb.sv
// self-checking bench for the status/aux/clock tile over axi4-lite
// assumes fabric_model supplies the clock sources
`timescale 1ns/1ps
`include "sac_params.svh"

module status_aux_clock_control_tb import sac_pkg::*; ();
  logic clock, rst_n, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, appFastClock, statusIrq, routedReset;
  logic [7:0] awaddr, araddr, statusInputs, controlOut;
  logic [31:0] wdata, rdata, d;
  logic [3:0] wstrb, peripheralClocks, routedControlInputs, syncOutputPins, syncOutputEnable;
  logic [3:0] componentClockEnable, firmwareReset;
  logic [1:0] bresp, rresp, fifoBusStatus, fifoFlush, r;
  fifo_state_t [1:0] fifoState;
  int mismatches, tests_run, i, cnt, bad, chg;
  logic [5:0] fifoCase [8] = '{6'b00_100_0, 6'b00_011_1, 6'b01_000_0, 6'b01_001_1,
                               6'b10_011_0, 6'b10_010_1, 6'b11_001_0, 6'b11_010_1};
  // mode, enable invert, rc bit, source, ticks expected, clock invert
  logic [8:0] clkCase [8] = '{9'b00_0_1_100_0_0, 9'b01_0_0_100_1_1, 9'b01_0_0_110_0_0, 9'b01_0_0_000_1_0,
                              9'b11_0_0_100_0_0, 9'b11_0_1_100_1_0, 9'b11_1_0_100_1_0, 9'b10_0_0_100_0_0};

  status_aux_clock_control status_aux_clock_control_inst (
    .clock(clock), .rst_n(rst_n), .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .peripheralClocks(peripheralClocks), .appFastClock(appFastClock),
    .routedControlInputs(routedControlInputs), .statusInputs(statusInputs), .fifoState(fifoState),
    .syncOutputPins(syncOutputPins), .syncOutputEnable(syncOutputEnable), .controlOut(controlOut),
    .statusIrq(statusIrq), .fifoBusStatus(fifoBusStatus), .fifoFlush(fifoFlush),
    .componentClockEnable(componentClockEnable), .routedReset(routedReset), .firmwareReset(firmwareReset));
  fabric_model fabric_model_inst (.peripheralClocks(peripheralClocks), .appFastClock(appFastClock));

  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  task automatic final_report();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic timedOut();
    mismatches++;
    $display("[FAIL] %0t wait timed out", $time);
    final_report();
  endtask

  task automatic axiWrite(input logic [7:0] a, input logic [31:0] v, output logic [1:0] resp);
    int n;
    @(posedge clock);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clock);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid && bready) begin
        resp = bresp;
        bready <= 1'b0;
        break;
      end
    end
    if (n == 50) timedOut();
  endtask

  task automatic axiRead(input logic [7:0] a, output logic [31:0] v, output logic [1:0] resp);
    int n;
    @(posedge clock);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clock);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid && rready) begin
        v = rdata;
        resp = rresp;
        rready <= 1'b0;
        break;
      end
    end
    if (n == 50) timedOut();
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    axiWrite(a, v, r);
    chk(32'(r), 32'(`SAC_RESP_OKAY));
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    axiRead(a, d, r);
    chk(d, exp);
    chk(32'(r), 32'(`SAC_RESP_OKAY));
  endtask

  task automatic ticks(input int n, output int c);
    c = 0;
    repeat (n) begin
      @(posedge clock);
      c += int'(componentClockEnable[0]);
    end
  endtask

  task automatic watchCount(output int b, output int c);
    logic [7:0] last;
    b = 0;
    c = 0;
    repeat (2) @(posedge clock);
    last = controlOut;
    repeat (120) begin
      @(posedge clock);
      if (controlOut[6:0] > 7'h03 || controlOut[7] !== (controlOut[6:0] == 7'h00)) b++;
      if (controlOut !== last) c++;
      last = controlOut;
    end
  endtask

  initial begin
    {rst_n, awvalid, wvalid, bready, arvalid, rready, awaddr, araddr} <= '0;
    {wdata, statusInputs, routedControlInputs, fifoState} <= '0;
    wstrb <= 4'hF;
    repeat (4) @(posedge clock);
    rst_n <= 1'b1;
    rd(`SAC_OFF_AUX, `SAC_ZERO32);
    rd(8'h20, `SAC_ZERO32);
    wr(`SAC_OFF_AUX, 32'h0000_00FF);
    rd(`SAC_OFF_AUX, 32'h0000_003F);
    axiRead(8'h40, d, r);
    chk(32'(r), 32'(`SAC_RESP_SLVERR));
    chk(d, `SAC_ZERO32);
    for (i = 0; i < 8; i++) begin
      wr(`SAC_OFF_AUX, {29'h0, fifoCase[i][5], 2'b00});
      fifoState[0] <= {fifoCase[i][4], fifoCase[i][3:1]};
      repeat (3) @(posedge clock);
      chk(32'(fifoBusStatus[0]), 32'(fifoCase[i][0]));
    end
    wr(`SAC_OFF_AUX, 32'h0000_0001);
    repeat (3) @(posedge clock);
    chk(32'(fifoFlush), 32'h0000_0001);
    chk(32'(fifoBusStatus[0]), 32'h0000_0000);
    wr(`SAC_OFF_AUX, `SAC_ZERO32);
    repeat (3) @(posedge clock);
    chk(32'(fifoBusStatus[0]), 32'h0000_0001);
    wr(`SAC_OFF_CFG, 32'h0000_0020);
    wr(`SAC_OFF_MASK, 32'h0000_0001);
    statusInputs <= 8'h01;
    wr(`SAC_OFF_AUX, 32'h0000_0010);
    repeat (5) @(posedge clock);
    chk(32'(statusIrq), 32'h0000_0001);
    wr(`SAC_OFF_AUX, `SAC_ZERO32);
    repeat (5) @(posedge clock);
    chk(32'(statusIrq), 32'h0000_0000);
    for (i = 0; i < 8; i++) begin
      routedControlInputs <= {3'h0, clkCase[i][5]};
      wr(8'h20, {23'h0, clkCase[i][8:7], clkCase[i][6], 2'b00, clkCase[i][0], clkCase[i][4:2]});
      repeat (10) @(posedge clock);
      ticks(60, cnt);
      chk(32'(cnt != 0), 32'(clkCase[i][1]));
    end
    // one tick per enable rise, enable slower than half the source
    routedControlInputs <= 4'h1;
    ticks(80, cnt);
    chk(32'(cnt), 32'h0000_0001);
    // status clock selected before counter or sync use
    wr(8'h2C, {23'h0, CLK_ON, 1'b0, 2'b00, 1'b0, `SAC_SRC_APP});
    wr(`SAC_OFF_CFG, 32'h0000_0022);
    wr(`SAC_OFF_MASK, 32'h0000_0003);
    wr(`SAC_OFF_CTL, 32'h0000_0003);
    statusInputs <= 8'h03;
    watchCount(bad, chg);
    chk(32'(chg), 32'h0000_0000);
    wr(`SAC_OFF_AUX, 32'h0000_0030);
    watchCount(bad, chg);
    chk(32'(bad), 32'h0000_0000);
    chk(32'(chg != 0), 32'h0000_0001);
    chk(32'(statusIrq), 32'h0000_0000);
    // sync mode, sticky mask set, reload and gate left off
    statusInputs <= 8'h0A;
    wr(`SAC_OFF_CFG, 32'h0000_3FC3);
    for (i = 0; i < 100 && syncOutputPins !== 4'hA; i++) @(posedge clock);
    if (i == 100) timedOut();
    chk(32'(syncOutputEnable), 32'h0000_000F);
    rd(`SAC_OFF_STATUS, 32'h0000_000A);
    statusInputs <= 8'h05;
    for (i = 0; i < 100 && syncOutputPins !== 4'h5; i++) @(posedge clock);
    if (i == 100) timedOut();
    rd(`SAC_OFF_STATUS, 32'h0000_0005);
    watchCount(bad, chg);
    chk(32'(chg != 0), 32'h0000_0001);
    // sticky capture outside sync, routed and firmware resets
    wr(`SAC_OFF_FWRST, 32'h0000_0005);
    chk(32'(firmwareReset), 32'h0000_0005);
    statusInputs <= 8'h01;
    wr(`SAC_OFF_CFG, 32'h0002_0040);
    repeat (8) @(posedge clock);
    chk(32'(routedReset), 32'h0000_0001);
    statusInputs <= 8'h00;
    routedControlInputs <= 4'h0;
    repeat (8) @(posedge clock);
    chk(32'(routedReset), 32'h0000_0000);
    rd(`SAC_OFF_STATUS, 32'h0000_0001);
    rd(`SAC_OFF_STATUS, `SAC_ZERO32);
    final_report();
  end
endmodule // status_aux_clock_control_tb
